// ### rtl/memory_map_consts.vh
// Address map, register offsets and reset values of the memory map decoder
`ifndef MEMORY_MAP_CONSTS_VH
`define MEMORY_MAP_CONSTS_VH

// Address space regions
`define MAP_REG_BASE        16'h0000
`define MAP_REG_LAST        16'h007F
`define MAP_RAM_BASE        16'h0080
`define MAP_RAM_LAST        16'h00FF
`define MAP_STACK_BASE      16'h00C0
`define MAP_STACK_LAST      16'h00FF
`define MAP_CAL_BASE        16'hDEE0
`define MAP_CAL_LAST        16'hDEE3
`define MAP_FLASH_BASE      16'hFC00
`define MAP_SECT0_BASE_BIG  16'hF800
`define MAP_SECT0_BASE_SML  16'hFE00
`define MAP_FLASH_LAST      16'hFFFF

// Register offsets inside the register block
`define OFS_PORT_OUT        7'h00
`define OFS_PORT_DIR        7'h01
`define OFS_PORT_OPT        7'h02
`define OFS_LT_CSR          7'h0B
`define OFS_LT_CAP          7'h0C
`define OFS_AT_CSR          7'h0D
`define OFS_AT_CNTH         7'h0E
`define OFS_AT_CNTL         7'h0F
`define OFS_AT_RELH         7'h10
`define OFS_AT_RELL         7'h11
`define OFS_PWM_CTRL        7'h12
`define OFS_PWM_STAT        7'h13
`define OFS_DUTY_H          7'h17
`define OFS_DUTY_L          7'h18
`define OFS_PMEM_CSR        7'h2F
`define OFS_ADC_CSR         7'h34
`define OFS_ADC_RESH        7'h35
`define OFS_ADC_RESL        7'h36
`define OFS_IRQ_SENSE1      7'h37
`define OFS_MCLK_CSR        7'h38
`define OFS_OSC_TRIM        7'h39
`define OFS_SYS_INTEG       7'h3A
`define OFS_IRQ_SENSE2      7'h3D
`define OFS_VWARN_THR       7'h3E
`define OFS_CLK_SRC         7'h3F
// Status word at FFF0h-FFF3h, as the word index paddr[15:2]
`define APB_STATUS_ADDR     14'h3FFC

// Reset values
`define RST_ZERO            8'h00
`define RST_PORT_DIR        8'h08
`define RST_PORT_OPT        8'h02
`define RST_OSC_TRIM        8'hFF
`define RST_VWARN_THR       8'h03
`define RST_CLK_SRC         8'h09
`define RST_SYS_INTEG       8'h00
`define RST_LT_CSR          8'h00
`define RST_ADC_RESH        8'h00

`endif

// ### rtl/memory_map_decoder.v
// Memory map decoder with peripheral register bank, reached over APB
// What this block does
// - Decode a flat 64K byte address space
// - Register block, RAM and program memory populated
// - Stack is RAM 00C0h through 00FFh
// - Two flash sectors on top, vectors in sector 0
// - Option byte sets sector 0 size
// - Calibration bytes DEE0h-DEE3h, readable in user mode
// - Calibration bytes survive array erase
// - Capture register read-only, resets 00h
// - Reload counter bytes read-only, reset 00h
// - Documented non-zero reset values loaded
// - Integrity register resets 0000 0x00
// - Port read returns pin level for inputs
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "memory_map_consts.vh"

module memory_map_decoder #(
   parameter PORT_BONDED = 8'h3F,  // Pins bonded out on the package
   parameter CAL_BYTE0   = 8'h80,  // Factory calibration, arbitrary default
   parameter CAL_BYTE1   = 8'h80,
   parameter CAL_BYTE2   = 8'h80,
   parameter CAL_BYTE3   = 8'h80
) (
   // APB clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [15:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Device state inputs
   input  wire        user_mode,
   input  wire        sector0_big_opt,
   input  wire [7:0]  port_pins,
   input  wire [15:0] reload_count,
   input  wire [7:0]  capture_value,
   input  wire [7:0]  result_high,
   input  wire        result_high_load,
   input  wire [7:0]  integ_flags,
   // Region selects towards memories
   output reg         sel_reg_ff,
   output reg         sel_ram_ff,
   output reg         sel_stack_ff,
   output reg         sel_flash0_ff,
   output reg         sel_flash1_ff,
   output reg         sel_cal_ff,
   output reg         reserved_hit_ff,
   // Register outputs to peripherals
   output reg  [7:0]  port_a_output_value_ff,
   output reg  [7:0]  port_a_direction_ff,
   output reg  [7:0]  port_a_pin_options_ff,
   output reg  [7:0]  oscillator_trim_ff,
   output reg  [7:0]  clock_source_ctrl_status_ff,
   output reg  [7:0]  voltage_warning_threshold_ff
);

   ////////////////////////////////////////////////////////////////////////////
   // Register storage not brought out as ports
   reg  [7:0]  light_timer_ctrl_status_ff;
   reg  [7:0]  reload_timer_ctrl_status_ff;
   reg  [7:0]  reload_value_high_ff;
   reg  [7:0]  reload_value_low_ff;
   reg  [7:0]  pulse_output_control_ff;
   reg  [7:0]  pulse_channel_zero_status_ff;
   reg  [7:0]  duty_cycle_high_ff;
   reg  [7:0]  duty_cycle_low_ff;
   reg  [7:0]  program_memory_ctrl_status_ff;
   reg  [7:0]  converter_ctrl_status_ff;
   reg  [7:0]  converter_result_high_ff;
   reg  [7:0]  converter_result_low_ff;
   reg  [7:0]  ext_irq_sense_first_ff;
   reg  [7:0]  ext_irq_sense_second_ff;
   reg  [7:0]  main_clock_ctrl_status_ff;
   reg  [7:0]  system_integrity_status_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Address decoding
   wire        setup    = psel & ~penable;
   wire        wr_acc   = psel & penable & pwrite;
   wire [6:0]  ofs      = paddr[6:0];
   wire [15:0] sect0_base;
   reg         nxt_reg, nxt_ram, nxt_stack, nxt_f0, nxt_f1, nxt_cal, nxt_rsv;
   reg         mapped;
   reg  [7:0]  rd_byte;
   reg  [7:0]  port_read;

   // Sector boundary follows the option byte, not a fixed address
   assign sect0_base = sector0_big_opt ? `MAP_SECT0_BASE_BIG
                                       : `MAP_SECT0_BASE_SML;

   // Region selection over the whole 16-bit space
   always @* begin
      nxt_reg   = 1'b0;
      nxt_ram   = 1'b0;
      nxt_stack = 1'b0;
      nxt_f0    = 1'b0;
      nxt_f1    = 1'b0;
      nxt_cal   = 1'b0;
      nxt_rsv   = 1'b0;

      if (paddr <= `MAP_REG_LAST) begin
         nxt_reg = 1'b1;
      end else if (paddr <= `MAP_RAM_LAST) begin
         nxt_ram   = 1'b1;
         nxt_stack = (paddr >= `MAP_STACK_BASE);
      end else if (paddr >= `MAP_CAL_BASE && paddr <= `MAP_CAL_LAST) begin
         nxt_cal = 1'b1;
      // A big sector 0 still stops at the bottom of the 1K array
      end else if (paddr >= sect0_base && paddr >= `MAP_FLASH_BASE) begin
         nxt_f0 = 1'b1;
      end else if (paddr >= `MAP_FLASH_BASE) begin
         nxt_f1 = 1'b1;
      end else begin
         nxt_rsv = 1'b1;
      end
   end

   // Port read returns live pins for input bits
   always @* begin
      port_read = (port_a_output_value_ff & port_a_direction_ff)
                | (port_pins & ~port_a_direction_ff);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexer; reserved offsets read zero and flag an error
   always @* begin
      rd_byte = 8'h00;
      mapped  = 1'b1;

      if (ofs == `OFS_PORT_OUT) begin
         rd_byte = port_read;
      end else if (ofs == `OFS_PORT_DIR) begin
         rd_byte = port_a_direction_ff;
      end else if (ofs == `OFS_PORT_OPT) begin
         rd_byte = port_a_pin_options_ff;

      end else if (ofs == `OFS_LT_CSR) begin
         rd_byte = light_timer_ctrl_status_ff;
      end else if (ofs == `OFS_LT_CAP) begin
         rd_byte = capture_value;

      end else if (ofs == `OFS_AT_CSR) begin
         rd_byte = reload_timer_ctrl_status_ff;
      end else if (ofs == `OFS_AT_CNTH) begin
         rd_byte = reload_count[15:8];
      end else if (ofs == `OFS_AT_CNTL) begin
         rd_byte = reload_count[7:0];
      end else if (ofs == `OFS_AT_RELH) begin
         rd_byte = reload_value_high_ff;
      end else if (ofs == `OFS_AT_RELL) begin
         rd_byte = reload_value_low_ff;
      end else if (ofs == `OFS_PWM_CTRL) begin
         rd_byte = pulse_output_control_ff;
      end else if (ofs == `OFS_PWM_STAT) begin
         rd_byte = pulse_channel_zero_status_ff;

      end else if (ofs == `OFS_DUTY_H) begin
         rd_byte = duty_cycle_high_ff;
      end else if (ofs == `OFS_DUTY_L) begin
         rd_byte = duty_cycle_low_ff;

      end else if (ofs == `OFS_PMEM_CSR) begin
         rd_byte = program_memory_ctrl_status_ff;

      end else if (ofs == `OFS_ADC_CSR) begin
         rd_byte = converter_ctrl_status_ff;
      end else if (ofs == `OFS_ADC_RESH) begin
         rd_byte = converter_result_high_ff;
      end else if (ofs == `OFS_ADC_RESL) begin
         rd_byte = converter_result_low_ff;

      end else if (ofs == `OFS_IRQ_SENSE1) begin
         rd_byte = ext_irq_sense_first_ff;
      end else if (ofs == `OFS_MCLK_CSR) begin
         rd_byte = main_clock_ctrl_status_ff;

      end else if (ofs == `OFS_OSC_TRIM) begin
         rd_byte = oscillator_trim_ff;
      end else if (ofs == `OFS_SYS_INTEG) begin
         rd_byte = system_integrity_status_ff;

      end else if (ofs == `OFS_IRQ_SENSE2) begin
         rd_byte = ext_irq_sense_second_ff;
      end else if (ofs == `OFS_VWARN_THR) begin
         rd_byte = voltage_warning_threshold_ff;
      end else if (ofs == `OFS_CLK_SRC) begin
         rd_byte = clock_source_ctrl_status_ff;
      end else begin
         mapped = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB answer: no wait state, data and error valid with pready
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else if (setup) begin
         pready  <= 1'b1;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         if (nxt_reg) begin
            pslverr <= ~mapped;
            if (!pwrite) begin
               prdata <= {24'h000000, rd_byte};
            end
         end else if (nxt_cal) begin
            // Constants outside the array, so an erase cannot lose them
            pslverr <= ~user_mode | pwrite;
            if (!pwrite && user_mode) begin
               case (paddr[1:0])
                  2'b00:   prdata <= {24'h000000, CAL_BYTE0};
                  2'b01:   prdata <= {24'h000000, CAL_BYTE1};
                  2'b10:   prdata <= {24'h000000, CAL_BYTE2};
                  default: prdata <= {24'h000000, CAL_BYTE3};
               endcase
            end
         end else if (paddr[15:2] == `APB_STATUS_ADDR) begin
            // Status word: user mode, option, last region flags
            prdata <= {24'h000000, user_mode, sector0_big_opt,
                       sel_reg_ff, sel_ram_ff, sel_stack_ff,
                       sel_flash0_ff, sel_flash1_ff, reserved_hit_ff};
         end else if (nxt_rsv) begin
            pslverr <= 1'b1; // Reserved space answers with an error
         end
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Region select outputs, latched in the setup cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_reg_ff      <= 1'b0;
         sel_ram_ff      <= 1'b0;
         sel_stack_ff    <= 1'b0;
         sel_flash0_ff   <= 1'b0;
         sel_flash1_ff   <= 1'b0;
         sel_cal_ff      <= 1'b0;
         reserved_hit_ff <= 1'b0;
      end else if (setup) begin
         sel_reg_ff      <= nxt_reg;
         sel_ram_ff      <= nxt_ram;
         sel_stack_ff    <= nxt_stack;
         sel_flash0_ff   <= nxt_f0;
         sel_flash1_ff   <= nxt_f1;
         sel_cal_ff      <= nxt_cal;
         reserved_hit_ff <= nxt_rsv;   // Trace of misuse until the next setup
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes; read-only and reserved offsets fall through untouched
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_a_output_value_ff        <= `RST_ZERO;
         port_a_direction_ff           <= `RST_PORT_DIR;
         port_a_pin_options_ff         <= `RST_PORT_OPT;

         light_timer_ctrl_status_ff    <= `RST_LT_CSR;

         reload_timer_ctrl_status_ff   <= `RST_ZERO;
         reload_value_high_ff          <= `RST_ZERO;
         reload_value_low_ff           <= `RST_ZERO;

         pulse_output_control_ff       <= `RST_ZERO;
         pulse_channel_zero_status_ff  <= `RST_ZERO;
         duty_cycle_high_ff            <= `RST_ZERO;
         duty_cycle_low_ff             <= `RST_ZERO;

         program_memory_ctrl_status_ff <= `RST_ZERO;

         converter_ctrl_status_ff      <= `RST_ZERO;
         converter_result_high_ff      <= `RST_ADC_RESH;
         converter_result_low_ff       <= `RST_ZERO;

         ext_irq_sense_first_ff        <= `RST_ZERO;
         ext_irq_sense_second_ff       <= `RST_ZERO;
         main_clock_ctrl_status_ff     <= `RST_ZERO;

         oscillator_trim_ff            <= `RST_OSC_TRIM;
         system_integrity_status_ff    <= `RST_SYS_INTEG;
         voltage_warning_threshold_ff  <= `RST_VWARN_THR;
         clock_source_ctrl_status_ff   <= `RST_CLK_SRC;
      end else begin
         // Result high byte is filled only by the converter
         if (result_high_load) begin
            converter_result_high_ff <= result_high;
         end

         // Integrity flags set by hardware; set wins over a write
         if (wr_acc && nxt_reg && ofs == `OFS_SYS_INTEG) begin
            system_integrity_status_ff <= pwdata[7:0] | integ_flags;
         end else begin
            system_integrity_status_ff <= system_integrity_status_ff | integ_flags;
         end

         if (wr_acc && nxt_reg) begin
            if (ofs == `OFS_PORT_OUT) begin
               // Unbonded bits held at reset value in hardware
               port_a_output_value_ff <= pwdata[7:0] & PORT_BONDED;
            end else if (ofs == `OFS_PORT_DIR) begin
               port_a_direction_ff <= (pwdata[7:0] & PORT_BONDED)
                                    | (`RST_PORT_DIR & ~PORT_BONDED);
            end else if (ofs == `OFS_PORT_OPT) begin
               port_a_pin_options_ff <= (pwdata[7:0] & PORT_BONDED)
                                      | (`RST_PORT_OPT & ~PORT_BONDED);

            end else if (ofs == `OFS_LT_CSR) begin
               light_timer_ctrl_status_ff <= pwdata[7:0];

            end else if (ofs == `OFS_AT_CSR) begin
               reload_timer_ctrl_status_ff <= pwdata[7:0];
            end else if (ofs == `OFS_AT_RELH) begin
               reload_value_high_ff <= pwdata[7:0];
            end else if (ofs == `OFS_AT_RELL) begin
               reload_value_low_ff <= pwdata[7:0];
            end else if (ofs == `OFS_PWM_CTRL) begin
               pulse_output_control_ff <= pwdata[7:0];
            end else if (ofs == `OFS_PWM_STAT) begin
               pulse_channel_zero_status_ff <= pwdata[7:0];

            end else if (ofs == `OFS_DUTY_H) begin
               duty_cycle_high_ff <= pwdata[7:0];
            end else if (ofs == `OFS_DUTY_L) begin
               duty_cycle_low_ff <= pwdata[7:0];

            end else if (ofs == `OFS_PMEM_CSR) begin
               program_memory_ctrl_status_ff <= pwdata[7:0];

            end else if (ofs == `OFS_ADC_CSR) begin
               converter_ctrl_status_ff <= pwdata[7:0];
            end else if (ofs == `OFS_ADC_RESL) begin
               converter_result_low_ff <= pwdata[7:0];

            end else if (ofs == `OFS_IRQ_SENSE1) begin
               ext_irq_sense_first_ff <= pwdata[7:0];
            end else if (ofs == `OFS_MCLK_CSR) begin
               main_clock_ctrl_status_ff <= pwdata[7:0];

            end else if (ofs == `OFS_OSC_TRIM) begin
               oscillator_trim_ff <= pwdata[7:0];
            end else if (ofs == `OFS_IRQ_SENSE2) begin
               ext_irq_sense_second_ff <= pwdata[7:0];
            end else if (ofs == `OFS_VWARN_THR) begin
               voltage_warning_threshold_ff <= pwdata[7:0];
            end else if (ofs == `OFS_CLK_SRC) begin
               clock_source_ctrl_status_ff <= pwdata[7:0];
            end
            // Capture, counter and result-high offsets are read-only
         end
      end
   end

endmodule

// ### verif/decoder_props.sv
// Concurrent checks on the memory map decoder ports
`timescale 1ns/1ps

module decoder_props (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB slave side
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Device state
   input wire logic        user_mode,
   input wire logic        sector0_big_opt,
   // Region selects
   input wire logic        sel_ram_ff,
   input wire logic        sel_stack_ff,
   input wire logic        sel_flash0_ff,
   input wire logic        sel_flash1_ff,
   // Register contents
   input wire logic [7:0]  port_a_output_value_ff,
   input wire logic [7:0]  port_a_direction_ff,
   input wire logic [7:0]  port_a_pin_options_ff,
   input wire logic [7:0]  oscillator_trim_ff,
   input wire logic [7:0]  clock_source_ctrl_status_ff,
   input wire logic [7:0]  voltage_warning_threshold_ff
);
   // Single domain, so clock and reset cut-off are given once
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Helpers; $past only ever sees plain signals
   wire       setup    = psel & ~penable;
   wire       cal_lock = setup & (paddr[15:2] == 14'h37B8) & ~user_mode;
   wire [7:0] wbyte    = pwdata[7:0];
   wire [47:0] regs = {port_a_output_value_ff, port_a_direction_ff, port_a_pin_options_ff,
                       oscillator_trim_ff, clock_source_ctrl_status_ff,
                       voltage_warning_threshold_ff};

   answer_next_a: assert property (setup |=> pready)
      else $error("no answer in the cycle after setup");
   answer_pulse_a: assert property (pready |=> !pready)
      else $error("answer held longer than one cycle");
   reset_load_a: assert property ($rose(presetn) |-> regs == 48'h000802FF0903)
      else $error("register contents wrong after reset");
   trim_write_a: assert property (setup && pwrite && paddr == 16'h0039
      |=> ##1 oscillator_trim_ff == $past(wbyte, 2)) else $error("trim write not stored");
   unpop_still_a: assert property (setup && pwrite && paddr == 16'h0003
      |-> ##2 $stable(regs)) else $error("unpopulated write changed a register");
   cal_locked_a: assert property (pready && $past(cal_lock) |-> pslverr && prdata == 32'h0)
      else $error("calibration byte readable outside user mode");
   stack_sel_a: assert property (setup && paddr[15:6] == 10'h003
      |=> sel_stack_ff && sel_ram_ff) else $error("stack address not decoded as stack");
   vector_sel_a: assert property (setup && paddr[15:9] == 7'h7F && paddr[15:4] != 12'hFFF
      |=> sel_flash0_ff && !sel_flash1_ff) else $error("vector area not in sector 0");
   sector_opt_a: assert property (setup && paddr[15:9] == 7'h7E
      |=> sel_flash1_ff == !$past(sector0_big_opt)) else $error("sector split ignores option");

   // Main scenarios reached
   cover property (setup && pwrite);
   cover property (cal_lock);
   cover property (setup && sector0_big_opt && paddr[15:9] == 7'h7E);
endmodule

bind memory_map_decoder decoder_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .user_mode(user_mode), .sector0_big_opt(sector0_big_opt),
   .sel_ram_ff(sel_ram_ff), .sel_stack_ff(sel_stack_ff), .sel_flash0_ff(sel_flash0_ff),
   .sel_flash1_ff(sel_flash1_ff), .port_a_output_value_ff(port_a_output_value_ff),
   .port_a_direction_ff(port_a_direction_ff), .port_a_pin_options_ff(port_a_pin_options_ff),
   .oscillator_trim_ff(oscillator_trim_ff),
   .clock_source_ctrl_status_ff(clock_source_ctrl_status_ff),
   .voltage_warning_threshold_ff(voltage_warning_threshold_ff));

// ### verif/cpu_bus_master.sv
// Behavioural CPU-side master issuing APB accesses to the decoder
`timescale 1ns/1ps

module cpu_bus_master (
   // Clock
   input  wire logic        pclk,
   // APB master side
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [15:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   // Raised when an answer never came
   output logic             bus_hung
);
   // Idle bus from time zero
   initial begin
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 16'h0000;
      pwdata   = 32'h00000000;
      bus_hung = 1'b0;
   end

   // One transfer; a leading edge keeps a following call from reassigning psel in one step
   task automatic xfer(input logic wr, input logic [15:0] addr, input logic [7:0] wdat,
                       output logic [31:0] rdat, output logic err);
      int n;
      begin
         n = 0;
         @(posedge pclk);
         psel    <= 1'b1;
         penable <= 1'b0;
         pwrite  <= wr;
         paddr   <= addr;
         pwdata  <= {24'h000000, wdat};
         @(posedge pclk);
         penable <= 1'b1;
         // Request held until pready is seen high at an edge
         do begin
            @(posedge pclk);
            n = n + 1;
         end while (pready !== 1'b1 && n < 64);
         rdat = prdata;
         err  = pslverr;
         if (n >= 64) begin
            bus_hung <= 1'b1;
         end
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask
endmodule

// ### verif/mcu_memory_map_decoder_tb.sv
// Self-checking bench of the memory map decoder driven through the CPU master model
`timescale 1ns/1ps

module mcu_memory_map_decoder_tb;
   // Bus, device state and outputs
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_hung, err;
   logic        user_mode, sector0_big_opt, result_high_load;
   logic [15:0] paddr, reload_count;
   logic [31:0] pwdata, prdata, rdat;
   logic [7:0]  port_pins, capture_value, result_high, integ_flags;
   logic        sel_reg_ff, sel_ram_ff, sel_stack_ff, sel_flash0_ff, sel_flash1_ff;
   logic        sel_cal_ff, reserved_hit_ff;
   logic [7:0]  port_a_output_value_ff, port_a_direction_ff, port_a_pin_options_ff;
   logic [7:0]  oscillator_trim_ff, clock_source_ctrl_status_ff, voltage_warning_threshold_ff;
   int          failures, num_checks;
   // Offset and reset value, then writable offsets, read-only, gaps, {address, option, selects}
   logic [15:0] rst_tab [0:24] = '{16'h0000, 16'h0108, 16'h0202, 16'h0B00, 16'h0C00, 16'h0D00,
      16'h0E00, 16'h0F00, 16'h1000, 16'h1100, 16'h1200, 16'h1300, 16'h1700, 16'h1800, 16'h2F00,
      16'h3400, 16'h3500, 16'h3600, 16'h3700, 16'h3800, 16'h39FF, 16'h3A00, 16'h3D00, 16'h3E03,
      16'h3F09};
   logic [7:0]  rw_tab [0:16] = '{8'h0B, 8'h0D, 8'h10, 8'h11, 8'h12, 8'h13, 8'h17, 8'h18, 8'h2F,
      8'h34, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3D, 8'h3E, 8'h3F};
   logic [7:0]  ro_tab [0:3] = '{8'h0C, 8'h0E, 8'h0F, 8'h35};
   logic [7:0]  gap_tab [0:7] = '{8'h03, 8'h0A, 8'h14, 8'h19, 8'h2E, 8'h30, 8'h3B, 8'h46};
   logic [24:0] map_tab [0:8] = '{{16'h0001, 1'h0, 8'h80}, {16'h0085, 1'h0, 8'h40},
      {16'h00C5, 1'h0, 8'h60}, {16'hFE10, 1'h0, 8'h10}, {16'hFC10, 1'h0, 8'h08},
      {16'hFC10, 1'h1, 8'h10}, {16'hDEE1, 1'h0, 8'h04}, {16'h8000, 1'h0, 8'h03},
      {16'hF900, 1'h1, 8'h03}};

   memory_map_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .user_mode(user_mode), .sector0_big_opt(sector0_big_opt),
      .port_pins(port_pins), .reload_count(reload_count), .capture_value(capture_value),
      .result_high(result_high), .result_high_load(result_high_load), .integ_flags(integ_flags),
      .sel_reg_ff(sel_reg_ff), .sel_ram_ff(sel_ram_ff), .sel_stack_ff(sel_stack_ff),
      .sel_flash0_ff(sel_flash0_ff), .sel_flash1_ff(sel_flash1_ff), .sel_cal_ff(sel_cal_ff),
      .reserved_hit_ff(reserved_hit_ff), .port_a_output_value_ff(port_a_output_value_ff),
      .port_a_direction_ff(port_a_direction_ff), .port_a_pin_options_ff(port_a_pin_options_ff),
      .oscillator_trim_ff(oscillator_trim_ff),
      .clock_source_ctrl_status_ff(clock_source_ctrl_status_ff),
      .voltage_warning_threshold_ff(voltage_warning_threshold_ff));
   cpu_bus_master cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus_hung(bus_hung));

   ////////////////////////////////////////////////////////////////////////////////
   // Compare, then read and write wrappers that also judge the error answer
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic e,
                     input logic [7:0] m);
      begin
         cpu.xfer(1'b0, a, 8'h00, rdat, err);
         check(rdat & {24'hFFFFFF, m}, {24'h000000, exp & m});
         check({31'h0, err}, {31'h0, e});
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic e);
      begin
         cpu.xfer(1'b1, a, d, rdat, err);
         check({31'h0, err}, {31'h0, e});
      end
   endtask
   task end_of_test;
      begin
         if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
         end else begin
            $display("Regression broken");
         end
         $finish;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, and the cut-off for a transfer that never answers
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge bus_hung) begin
      failures = failures + 1;
      end_of_test();
   end

   // Main sequence
   initial begin
      failures = 0;
      num_checks = 0;
      {presetn, sector0_big_opt, result_high_load} = 3'h0;
      user_mode = 1'b1;
      {port_pins, capture_value, result_high, reload_count} = 40'h0;
      integ_flags = 8'h00; // Hardware set of integrity flags not exercised
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rst_tab[i]) rd({8'h00, rst_tab[i][15:8]}, rst_tab[i][7:0], 1'b0,
         (rst_tab[i][15:8] == 8'h3A) ? 8'hFB : 8'hFF);
      foreach (rw_tab[i]) begin
         wr({8'h00, rw_tab[i]}, rw_tab[i] ^ 8'h5A, 1'b0);
         rd({8'h00, rw_tab[i]}, rw_tab[i] ^ 8'h5A, 1'b0, 8'hFF);
      end
      // Read-only places show the live peripheral values whatever is written
      capture_value <= 8'h77;
      reload_count <= 16'h1234;
      result_high <= 8'h9C;
      result_high_load <= 1'b1;
      @(posedge pclk);
      result_high_load <= 1'b0;
      foreach (ro_tab[i]) wr({8'h00, ro_tab[i]}, 8'hFF, 1'b0);
      rd(16'h000C, 8'h77, 1'b0, 8'hFF);
      rd(16'h000E, 8'h12, 1'b0, 8'hFF);
      rd(16'h000F, 8'h34, 1'b0, 8'hFF);
      rd(16'h0035, 8'h9C, 1'b0, 8'hFF);
      foreach (gap_tab[i]) begin
         wr({8'h00, gap_tab[i]}, 8'hFF, 1'b1);
         rd({8'h00, gap_tab[i]}, 8'h00, 1'b1, 8'hFF);
      end
      rd(16'h0039, 8'h63, 1'b0, 8'hFF);
      // Unbonded bits 7:6 left at zero; pins read back where direction is input
      wr(16'h0001, 8'h0F, 1'b0);
      wr(16'h0000, 8'h35, 1'b0);
      port_pins <= 8'h2A;
      rd(16'h0000, 8'h25, 1'b0, 8'hFF);
      for (int i = 0; i < 4; i++) rd(16'hDEE0 + i[15:0], 8'h80, 1'b0, 8'hFF);
      user_mode <= 1'b0;
      rd(16'hDEE2, 8'h00, 1'b1, 8'hFF);
      user_mode <= 1'b1;
      foreach (map_tab[i]) begin
         sector0_big_opt <= map_tab[i][8];
         cpu.xfer(1'b0, map_tab[i][24:9], 8'h00, rdat, err);
         check({24'h0, sel_reg_ff, sel_ram_ff, sel_stack_ff, sel_flash0_ff, sel_flash1_ff,
            sel_cal_ff, reserved_hit_ff, err}, {24'h0, map_tab[i][7:0]});
      end
      // Second reset in mid-run restores the trim value
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(16'h0039, 8'hFF, 1'b0, 8'hFF);
      end_of_test();
   end
endmodule
